//--- test/ets_trig_src.sv
// Experiment side model: trigger source driving the external sync pin
`timescale 1ns/100ps
module ets_trig_src (
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic falling,
  output logic      ext_trig
);
  logic [3:0] hold_q = 4'h0;
  always @(posedge clk) begin
    if (fire) hold_q <= 4'h8;
    else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
  end
  // Rests at the inactive level, so every pulse starts with the chosen edge
  assign ext_trig = falling ^ (hold_q != 4'h0);
endmodule

//--- test/tb.sv
// Self-checking bench for the exposure timing sequencer
`timescale 1ns/100ps
module tb;
  import ets_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        fire = 1'b0, pulse = 1'b0, fall = 1'b0, noise = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        ext_trig, shut, ro_n, sync, tick;
  int          n_mismatch = 0, total_checks = 0, fe, fcr, fr, ft, fs, cyc = 0;

  always #10 clk = ~clk;
  // Trigger noise keeps firing while free run must ignore it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fire <= pulse | (noise & (cyc % 16 == 0));
  end

  ets_sequencer dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EXT_TRIG(ext_trig), .SHUTTER_OPEN(shut),
    .READOUT_N(ro_n), .SYNC_OUT(sync), .CONV_TICK(tick));
  ets_trig_src src (.clk(clk), .fire(fire), .falling(fall), .ext_trig(ext_trig));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask
  task start(input logic [1:0] m, input logic [1:0] s, input logic e, input logic o,
             input logic sl);
    fall <= e;
    wr_reg(ADDR_CTRL, {24'h0, sl, o, e, s, m, 1'b1});
  endtask
  task stop;
    int k;
    k = 0;
    wr_reg(ADDR_CTRL, 32'h0);
    do begin rd_reg(ADDR_STATUS, d); k++; end while (d[2:0] != 3'h0 && k < 3000);
    chk(d[2:0], 3'h0);
  endtask
  task fire_once;
    @(posedge clk); pulse <= 1'b1;
    @(posedge clk); pulse <= 1'b0;
  endtask
  // One frame from shutter opening to reopening or end of readout
  task frame(input int bound);
    int k;
    k = 0; fe = 0; fcr = 0; fr = 0; ft = 0; fs = 0;
    while (shut !== 1'b1 && k < bound) begin @(negedge clk); k++; end
    chk(k < bound, 1);
    while (shut === 1'b1 && fe < 5000) begin
      fs += (sync === 1'b0); fe++; @(negedge clk);
    end
    while (shut === 1'b0 && !(fr > 0 && ro_n === 1'b1) && fcr < 5000) begin
      fr += (ro_n === 1'b0); ft += (tick === 1'b1); fs += (sync === 1'b0);
      fcr++; @(negedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk({shut, ro_n, sync, tick}, 4'b0100);
    rd_reg(ADDR_CTRL, d);
    chk(d, CTRL_RESET);
    rd_reg(ADDR_EXPOSURE, d);
    chk(d, EXPOSURE_RESET);
    rd_reg(ADDR_COMP, d);
    chk(d, COMP_RESET);
    rd_reg(ADDR_READOUT, d);
    chk(d, READOUT_RESET);
    rd_reg(4'hF, d);
    chk(d, 32'h0);
    wr_reg(ADDR_EXPOSURE, 32'h6);
    wr_reg(ADDR_COMP, 32'h3);
    wr_reg(ADDR_READOUT, 32'h5);
    rd_reg(ADDR_EXPOSURE, d);
    chk(d, 32'h6);
  endtask
  task t_free(input logic o);
    start(2'h0, SHUT_NORMAL, 1'b0, o, 1'b0);
    noise <= 1'b1;
    frame(20);
    noise <= 1'b0;
    chk(fe, 6);
    chk(fcr, 8);
    chk(fr, 5);
    chk(shut, 1);
    chk(fs, o ? 5 : 8);
    stop;
  endtask
  task t_trig(input logic [1:0] m, input logic e);
    start(m, SHUT_NORMAL, e, 1'b0, 1'b0);
    repeat (30) @(posedge clk);
    rd_reg(ADDR_STATUS, d);
    chk({shut, d[2:0]}, 4'h1);
    fire_once;
    frame(14);
    chk(fe, 6);
    chk(fr, 5);
    repeat (20) @(negedge clk);
    chk(shut, 0);
    stop;
  endtask
  task t_early(input logic [1:0] m);
    int k;
    start(m, SHUT_EARLY_OPEN, 1'b0, 1'b0, 1'b0);
    repeat (30) @(negedge clk);
    chk(shut, 1);
    fire_once;
    k = 0;
    while (ro_n !== 1'b0 && k < 40) begin @(negedge clk); k++; end
    chk(shut, 0);
    while (ro_n !== 1'b1 && k < 80) begin @(negedge clk); k++; end
    repeat (2) @(negedge clk);
    chk(shut, 1);
    stop;
  endtask
  task t_dis(input logic [1:0] s);
    int bad, low;
    bad = 0; low = 0;
    start(2'h0, s, 1'b0, 1'b0, 1'b0);
    // The shutter takes the new setting one edge after the write lands
    @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      bad += (shut !== (s == SHUT_DIS_OPEN)); low += (ro_n === 1'b0);
    end
    chk(bad, 0);
    chk(low >= 5, 1);
    stop;
  endtask
  task t_illegal(input logic [1:0] m, input logic [1:0] s);
    start(m, s, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_STATUS, d);
    chk({shut, ro_n, d[3:0]}, {s == SHUT_DIS_OPEN, 5'h18});
    wr_reg(ADDR_CTRL, 32'h0);
  endtask
  task t_rate(input logic sl);
    int q;
    q = 1000 / (sl ? SLOW_DIV : FAST_DIV);
    wr_reg(ADDR_READOUT, 32'd1000);
    start(2'h0, SHUT_NORMAL, 1'b0, 1'b0, sl);
    frame(20);
    chk(ft >= q - 1 && ft <= q + 1, 1);
    stop;
    wr_reg(ADDR_READOUT, 32'h5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_free(1'b1);
    t_free(1'b0);
    t_trig(MODE_TRIGGERED, 1'b0);
    t_trig(MODE_TRIG_CLEAN, 1'b1);
    t_early(MODE_TRIGGERED);
    t_early(MODE_TRIG_CLEAN);
    t_dis(SHUT_DIS_OPEN);
    t_dis(SHUT_DIS_CLOSED);
    t_illegal(2'h3, SHUT_NORMAL);
    t_illegal(2'h3, SHUT_DIS_OPEN);
    t_illegal(MODE_FREE_RUN, SHUT_EARLY_OPEN);
    t_rate(1'b0);
    t_rate(1'b1);
    report_and_stop;
  end
endmodule

//--- verilog/ets_pacer.sv
// Conversion pacer producing one pulse per pixel conversion
`timescale 1ns/100ps
module ets_pacer
  import ets_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic slow,
  output logic      tick
);
  logic [15:0] cnt_q;
  logic [15:0] limit;

  // Rate select comes only from the software control bit
  assign limit = slow ? SLOW_DIV : FAST_DIV;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q >= limit - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !slow && run) |=> !tick [*8])
    else $error("pacer ticks too close");
endmodule

//--- verilog/ets_pkg.sv
// Package of constants and types for the exposure timing sequencer
package ets_pkg;
  localparam logic [3:0]  ADDR_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_EXPOSURE    = 4'h1;
  localparam logic [3:0]  ADDR_COMP        = 4'h2;
  localparam logic [3:0]  ADDR_READOUT     = 4'h3;
  localparam logic [3:0]  ADDR_STATUS      = 4'h4;
  localparam int          CTRL_RUN_BIT     = 0;
  localparam int          CTRL_MODE_LSB    = 1;
  localparam int          CTRL_SHUT_LSB    = 3;
  localparam int          CTRL_EDGE_BIT    = 5;
  localparam int          CTRL_OUTSEL_BIT  = 6;
  localparam int          CTRL_RATE_BIT    = 7;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] EXPOSURE_RESET   = 32'h0000_0064;
  localparam logic [31:0] COMP_RESET       = 32'h0000_000A;
  localparam logic [31:0] READOUT_RESET    = 32'h0000_0064;
  localparam int          CLK_HZ           = 50000000;
  localparam int          FAST_RATE_HZ     = 1000000;
  localparam int          SLOW_RATE_HZ     = 100000;
  localparam logic [15:0] FAST_DIV         = 16'(CLK_HZ / FAST_RATE_HZ);
  localparam logic [15:0] SLOW_DIV         = 16'(CLK_HZ / SLOW_RATE_HZ);
  localparam logic [1:0]  MODE_FREE_RUN    = 2'h0;
  localparam logic [1:0]  MODE_TRIGGERED   = 2'h1;
  localparam logic [1:0]  MODE_TRIG_CLEAN  = 2'h2;
  localparam logic [1:0]  SHUT_NORMAL      = 2'h0;
  localparam logic [1:0]  SHUT_EARLY_OPEN  = 2'h1;
  localparam logic [1:0]  SHUT_DIS_OPEN    = 2'h2;
  localparam logic [1:0]  SHUT_DIS_CLOSED  = 2'h3;
  typedef enum logic [2:0] {
    ETS_IDLE, ETS_WAIT_SYNC, ETS_EXPOSE, ETS_COMP, ETS_READOUT
  } ets_state_t;
endpackage

//--- verilog/ets_sequencer.sv
// Exposure timing sequencer: shutter, exposure, compensation and readout
`timescale 1ns/100ps
//
// Overview of operation
// - Conversion pace is fast or low-noise, chosen only by a software bit.
// - Only eleven mode and shutter pairings are accepted; others are refused.
// - Four shutter options; both disabled options hold the drive fixed.
// - Early-open in triggered modes opens shutter when ready for sync.
// - Free run opens shutter right after readout, for the exposure time.
// - Free run ignores every external trigger edge.
// - Free run refuses early-open shutter as an illegal pairing.
// - Sync output shows shutter state or readout indicator, software chosen.
// - Frame order: expose, close, compensation, readout, then next exposure.
// - Readout indicator is low during readout and high otherwise.
// - Triggered normal: wait edge, open, expose, close, read out.
// - Trigger edge polarity is selectable rising or falling.
module ets_sequencer
  import ets_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        EXT_TRIG,
  output logic             SHUTTER_OPEN,
  output logic             READOUT_N,
  output logic             SYNC_OUT,
  output logic             CONV_TICK
);
  import ets_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [31:0] exposure_q;
  logic [31:0] comp_q;
  logic [31:0] readout_q;
  logic        illegal_q;
  logic [31:0] frames_q;
  ets_state_t  state_q;
  ets_state_t  state_d;
  logic [31:0] cnt_q;
  logic        trig_s1_q;
  logic        trig_s2_q;
  logic        trig_s3_q;
  logic        edge_seen;
  logic        run;
  logic [1:0]  mode;
  logic [1:0]  shut;
  logic        legal;
  logic        shut_d;
  logic        tick;

  function automatic logic pair_legal(input logic [1:0] m, input logic [1:0] s);
    logic ok;
    ok = 1'b0;
    case (m)
      MODE_FREE_RUN:   ok = (s == SHUT_NORMAL);
      MODE_TRIGGERED:  ok = (s == SHUT_NORMAL) || (s == SHUT_EARLY_OPEN);
      MODE_TRIG_CLEAN: ok = (s == SHUT_NORMAL) || (s == SHUT_EARLY_OPEN);
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign run  = ctrl_q[CTRL_RUN_BIT];
  assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
  assign shut = ctrl_q[CTRL_SHUT_LSB +: 2];
  // Disabled options are acquisition settings too, so they pass the check
  // An undefined mode code stays refused even with a disabled shutter
  assign legal = pair_legal(mode, shut) ||
                 ((shut == SHUT_DIS_OPEN || shut == SHUT_DIS_CLOSED) &&
                  (mode == MODE_FREE_RUN || mode == MODE_TRIGGERED ||
                   mode == MODE_TRIG_CLEAN));

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q     <= CTRL_RESET;
      exposure_q <= EXPOSURE_RESET;
      comp_q     <= COMP_RESET;
      readout_q  <= READOUT_RESET;
    end else if (WR) begin
      case (ADDR)
        ADDR_CTRL:     ctrl_q     <= {24'h000000, WDATA[7:0]};
        ADDR_EXPOSURE: exposure_q <= WDATA;
        ADDR_COMP:     comp_q     <= WDATA;
        ADDR_READOUT:  readout_q  <= WDATA;
        default:       ctrl_q     <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        ADDR_CTRL:     RDATA <= ctrl_q;
        ADDR_EXPOSURE: RDATA <= exposure_q;
        ADDR_COMP:     RDATA <= comp_q;
        ADDR_READOUT:  RDATA <= readout_q;
        ADDR_STATUS:   RDATA <= {frames_q[23:0], 4'h0, illegal_q, 3'(state_q)};
        default:       RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser; the second and third stages feed edge logic
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= EXT_TRIG;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Polarity bit high selects falling edges
  assign edge_seen = ctrl_q[CTRL_EDGE_BIT] ? (trig_s3_q && !trig_s2_q)
                                           : (!trig_s3_q && trig_s2_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ETS_IDLE: begin
        if (run && legal) begin
          state_d = (mode == MODE_FREE_RUN) ? ETS_EXPOSE : ETS_WAIT_SYNC;
        end
      end
      ETS_WAIT_SYNC: begin
        if (!run) begin
          state_d = ETS_IDLE;
        end else if (edge_seen) begin
          state_d = ETS_EXPOSE;
        end
      end
      ETS_EXPOSE: begin
        if (cnt_q <= 32'h0000_0001) begin
          state_d = ETS_COMP;
        end
      end
      ETS_COMP: begin
        if (cnt_q <= 32'h0000_0001) begin
          state_d = ETS_READOUT;
        end
      end
      ETS_READOUT: begin
        if (cnt_q <= 32'h0000_0001) begin
          // Free run ignores the trigger and restarts straight away
          if (!run || !legal) begin
            state_d = ETS_IDLE;
          end else if (mode == MODE_FREE_RUN) begin
            state_d = ETS_EXPOSE;
          end else begin
            state_d = ETS_WAIT_SYNC;
          end
        end
      end
      default: state_d = ETS_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ETS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Interval counter reloads on entry; zero is treated as one cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 32'h0000_0000;
    end else if (state_d != state_q || (state_q == ETS_READOUT && state_d == ETS_EXPOSE)) begin
      case (state_d)
        ETS_EXPOSE:  cnt_q <= exposure_q;
        ETS_COMP:    cnt_q <= comp_q;
        ETS_READOUT: cnt_q <= readout_q;
        default:     cnt_q <= 32'h0000_0000;
      endcase
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      illegal_q <= 1'b0;
      frames_q  <= 32'h0000_0000;
    end else begin
      illegal_q <= run && !legal;
      if (state_q == ETS_READOUT && state_d != ETS_READOUT) begin
        frames_q <= frames_q + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shutter and outputs
  always_comb begin
    shut_d = 1'b0;
    case (shut)
      SHUT_DIS_OPEN:   shut_d = 1'b1;
      SHUT_DIS_CLOSED: shut_d = 1'b0;
      SHUT_EARLY_OPEN: begin
        // Free run behaves as normal shutter
        shut_d = (state_d == ETS_EXPOSE) ||
                 (state_d == ETS_WAIT_SYNC && mode != MODE_FREE_RUN);
      end
      default: shut_d = (state_d == ETS_EXPOSE);
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SHUTTER_OPEN <= 1'b0;
      READOUT_N    <= 1'b1;
      SYNC_OUT     <= 1'b0;
    end else begin
      SHUTTER_OPEN <= shut_d;
      READOUT_N    <= (state_d != ETS_READOUT);
      SYNC_OUT     <= ctrl_q[CTRL_OUTSEL_BIT] ? (state_d != ETS_READOUT) : shut_d;
    end
  end

  ets_pacer u_pacer (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .run   (state_q == ETS_READOUT),
    .slow  (ctrl_q[CTRL_RATE_BIT]),
    .tick  (tick)
  );

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONV_TICK <= 1'b0;
    end else begin
      CONV_TICK <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_close_then_comp;
    (state_q == ETS_EXPOSE) ##1 (state_q == ETS_COMP);
  endsequence

  chk_frame_order: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (state_q == ETS_COMP) |=> (state_q == ETS_COMP || state_q == ETS_READOUT))
    else $error("compensation not followed by readout");
  chk_readout_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    READOUT_N == (state_q != ETS_READOUT))
    else $error("readout indicator not low in readout");
  chk_free_ignore: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (state_q == ETS_READOUT && mode == MODE_FREE_RUN) |-> (state_d != ETS_WAIT_SYNC))
    else $error("free run waited for trigger");
  chk_dis_closed: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (shut == SHUT_DIS_CLOSED) [*2] |-> !SHUTTER_OPEN)
    else $error("shutter moved while disabled closed");
  chk_dis_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (shut == SHUT_DIS_OPEN) [*2] |-> SHUTTER_OPEN)
    else $error("shutter moved while disabled open");
  chk_early_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (state_q == ETS_WAIT_SYNC && shut == SHUT_EARLY_OPEN) [*2] |-> SHUTTER_OPEN)
    else $error("early-open shutter closed while waiting");
  chk_comp_closed: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    s_close_then_comp |-> (shut == SHUT_DIS_OPEN) || !SHUTTER_OPEN)
    else $error("shutter open in compensation");
  chk_illegal_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (run && !legal) |=> illegal_q)
    else $error("illegal pairing not flagged");
  chk_sync_select: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $past(ctrl_q[CTRL_OUTSEL_BIT]) && ctrl_q[CTRL_OUTSEL_BIT] |-> SYNC_OUT == READOUT_N)
    else $error("sync output not following readout indicator");
endmodule
